// file: spi_status_pkg.sv
package spi_status_pkg;
   // Opcodes
   localparam logic [7:0] STATUS_READ_CMD = 8'h05;
   localparam logic [7:0] STATUS_READ_FAST_CMD = 8'h09;
   localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
   localparam logic [7:0] WRITE_LATCH_SET_CMD = 8'h06;
   localparam logic [7:0] WRITE_LATCH_CLEAR_CMD = 8'h04;
   localparam logic [7:0] ARRAY_READ_CMD = 8'h03;
   localparam logic [7:0] ARRAY_READ_FAST_CMD = 8'h0b;
   localparam logic [7:0] ARRAY_WRITE_CMD = 8'h02;
   localparam logic [7:0] CLOCK_REGS_READ_CMD = 8'h13;
   localparam logic [7:0] CLOCK_REGS_READ_FAST_CMD = 8'h1d;
   localparam logic [7:0] CLOCK_REGS_WRITE_CMD = 8'h12;
   localparam logic [7:0] SAVE_CMD = 8'h3c;
   localparam logic [7:0] RESTORE_CMD = 8'h60;
   localparam logic [7:0] AUTO_SAVE_ON_CMD = 8'h59;
   localparam logic [7:0] AUTO_SAVE_OFF_CMD = 8'h19;
   localparam logic [7:0] SLEEP_CMD = 8'hb9;
   localparam logic [7:0] SERIAL_ID_WRITE_CMD = 8'hc2;
   localparam logic [7:0] SERIAL_ID_READ_CMD = 8'hc3;
   localparam logic [7:0] SERIAL_ID_READ_FAST_CMD = 8'hc9;
   localparam logic [7:0] PART_ID_READ_CMD = 8'h9f;
   localparam logic [7:0] PART_ID_READ_FAST_CMD = 8'h99;
   localparam logic [7:0] RESERVED_CMD = 8'h1e;
   // Status field positions
   localparam int BUSY_BIT = 0;
   localparam int WRITE_LATCH_BIT = 1;
   localparam int BLOCK_GUARD_LO_BIT = 2;
   localparam int BLOCK_GUARD_HI_BIT = 3;
   localparam int SERIAL_ID_LOCK_BIT = 6;
   localparam int PROTECT_PIN_ENABLE_BIT = 7;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] STATUS_WRITE_MASK = 8'h8c;
   // Block guard address bounds
   localparam logic [16:0] GUARD_QUARTER_BASE = 17'h18000;
   localparam logic [16:0] GUARD_HALF_BASE = 17'h10000;
   // Standby entry delay
   localparam int STANDBY_ENTRY_DELAY_NS = 100;
   localparam int CLK_PERIOD_NS = 10;
   localparam int STANDBY_CYCLES = (STANDBY_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_OPCODE = 3'b001,
      ST_DUMMY = 3'b011,
      ST_SEND = 3'b010,
      ST_DATA_IN = 3'b110,
      ST_IGNORE = 3'b111
   } frame_state_t;

   typedef struct packed {
      logic sel_n;
      logic sck;
      logic mosi;
   } spi_in_t;

   typedef struct packed {
      logic save_start;
      logic restore_start;
      logic auto_save_on;
      logic auto_save_off;
      logic sleep_start;
      logic serial_id_write_ok;
      logic array_cmd;
      logic clock_regs_cmd;
      logic id_read_cmd;
   } cmd_events_t;
endpackage

// file: spi_nvsram_command_status.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Active while selected; standby after delay, busy done
// - Eight-bit opcode shifted MSB first per frame
// - Status read, fast read, write opcodes
// - Latch set and latch clear opcodes
// - Array read, fast read, write opcodes
// - Clock register read, fast read, write opcodes
// - Save, restore, auto-save on/off opcodes
// - Sleep, serial id write, read opcodes
// - Fast serial, part id reads; 0x1e reserved
// - Status layout: pin-enable, lock, guards, latch, busy
// - Busy bit read-only, high during save/restore
// - Status write changes only pin-enable and guards
// - Status bits reset to zero
// - Bits 4 and 5 always read zero
// - Write latch cleared at power-up
// - Serial id writes allowed until locked
// - Serial id lock set once, cleared only by reset
// - Normal status read: opcode then data
// - Fast status read: opcode, dummy byte, data
// - Invalid opcode ignored until next select
// - Guard bits select protected array range
// - Pin-enable with pin low blocks status write
// - Write or special command clears latch
module spi_nvsram_command_status
   import spi_status_pkg::*;
#(
   parameter int STANDBY_DELAY_CYCLES = STANDBY_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire spi_status_pkg::spi_in_t spi_in,
   input wire logic write_protect_n,
   input wire logic nv_busy,
   input wire logic serial_id_lock_set,
   input wire logic [16:0] array_addr,
   output logic miso_o,
   output logic miso_oe,
   output logic active_power,
   output logic [7:0] status_out,
   output logic addr_guarded,
   output spi_status_pkg::cmd_events_t cmd_events
);
   import spi_status_pkg::*;

   logic [2:0] sel_sync_reg, sck_sync_reg;
   logic [1:0] mosi_sync_reg;
   logic sel_n, sck, mosi;
   logic sck_rise, sck_fall, frame_start, frame_end;
   frame_state_t state_reg;
   logic [7:0] shift_reg, opcode_reg, tx_reg;
   logic [2:0] bit_cnt_reg;
   logic [1:0] guards_pin_reg;
   logic protect_pin_enable_reg, lock_reg, latch_reg;
   logic [7:0] status_word;
   logic [$clog2(STANDBY_DELAY_CYCLES + 1)-1:0] standby_cnt_reg;
   logic [1:0] wp_sync_reg;

   // Select and clock take three stages: first two synchronise, third only for edge finding; data and protect pin take two
   always_ff @(posedge clk_sys) begin
      sel_sync_reg <= {sel_sync_reg[1:0], spi_in.sel_n};
      sck_sync_reg <= {sck_sync_reg[1:0], spi_in.sck};
      mosi_sync_reg <= {mosi_sync_reg[0], spi_in.mosi};
      // Protect pin is asynchronous too
      wp_sync_reg <= {wp_sync_reg[0], write_protect_n};
   end
   assign sel_n = sel_sync_reg[1];
   assign sck = sck_sync_reg[1];
   assign mosi = mosi_sync_reg[1];
   assign frame_start = sel_sync_reg[2] & ~sel_n;
   assign frame_end = ~sel_sync_reg[2] & sel_n;
   assign sck_rise = sck & ~sck_sync_reg[2] & ~sel_n;
   assign sck_fall = ~sck & sck_sync_reg[2] & ~sel_n;

   assign status_word = {protect_pin_enable_reg, lock_reg, 2'b00, guards_pin_reg[1:0], latch_reg, nv_busy};
   assign status_out = status_word;

   wire [7:0] rx_byte = {shift_reg[6:0], mosi};
   wire byte_done = sck_rise & (bit_cnt_reg == 3'd7);
   wire is_status_read = rx_byte == STATUS_READ_CMD;
   wire is_status_read_fast = rx_byte == STATUS_READ_FAST_CMD;
   wire is_latch_write = rx_byte == STATUS_WRITE_CMD || rx_byte == ARRAY_WRITE_CMD
      || rx_byte == CLOCK_REGS_WRITE_CMD || rx_byte == SERIAL_ID_WRITE_CMD;
   wire is_special = rx_byte == SAVE_CMD || rx_byte == RESTORE_CMD
      || rx_byte == AUTO_SAVE_ON_CMD || rx_byte == AUTO_SAVE_OFF_CMD;
   wire is_other_read = rx_byte == ARRAY_READ_CMD || rx_byte == ARRAY_READ_FAST_CMD
      || rx_byte == CLOCK_REGS_READ_CMD || rx_byte == CLOCK_REGS_READ_FAST_CMD
      || rx_byte == SERIAL_ID_READ_CMD || rx_byte == SERIAL_ID_READ_FAST_CMD
      || rx_byte == PART_ID_READ_CMD || rx_byte == PART_ID_READ_FAST_CMD
      || rx_byte == SLEEP_CMD || rx_byte == WRITE_LATCH_SET_CMD
      || rx_byte == WRITE_LATCH_CLEAR_CMD;
   // reserved and unknown codes fall through to ignore
   wire opcode_valid = is_status_read | is_status_read_fast | is_latch_write
      | is_special | is_other_read;
   // Write-class opcodes need the latch; without it the frame is ignored
   wire opcode_allowed = opcode_valid & (latch_reg | ~(is_latch_write | is_special));
   // pin-enable with pin low blocks status write
   wire status_write_blocked = protect_pin_enable_reg & ~wp_sync_reg[1];
   // A cut frame leaves the last opcode stale
   wire opcode_seen = state_reg != ST_IDLE && state_reg != ST_OPCODE;
   wire status_write_done = state_reg == ST_DATA_IN && byte_done
      && opcode_reg == STATUS_WRITE_CMD;

   always_ff @(posedge clk_sys) begin
      if (rst || frame_start) begin
         bit_cnt_reg <= 3'd0;
         shift_reg <= 8'h00;
      end else if (sck_rise) begin
         bit_cnt_reg <= bit_cnt_reg + 3'd1;
         shift_reg <= rx_byte;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         opcode_reg <= 8'h00;
      end else if (sel_n) begin
         state_reg <= ST_IDLE;
      end else if (frame_start) begin
         state_reg <= ST_OPCODE;
      end else if (byte_done) begin
         case (state_reg)
            ST_OPCODE: begin
               opcode_reg <= rx_byte;
               if (!opcode_allowed)
                  state_reg <= ST_IGNORE;
               else if (is_status_read)
                  state_reg <= ST_SEND;
               else if (is_status_read_fast)
                  state_reg <= ST_DUMMY;
               else if (rx_byte == STATUS_WRITE_CMD)
                  state_reg <= ST_DATA_IN;
               else
                  state_reg <= ST_IGNORE;
            end
            ST_DUMMY: state_reg <= ST_SEND;
            ST_DATA_IN: state_reg <= ST_IGNORE;
            ST_SEND: state_reg <= ST_SEND;
            ST_IGNORE: state_reg <= ST_IGNORE;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // status out MSB first on falling edges
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tx_reg <= 8'h00;
         miso_o <= 1'b0;
      end else if (state_reg != ST_SEND) begin
         tx_reg <= status_word;
         miso_o <= 1'b0;
      end else if (sck_fall) begin
         miso_o <= tx_reg[7];
         tx_reg <= {tx_reg[6:0], tx_reg[7]};
      end
   end
   // output stays off outside a status read
   assign miso_oe = state_reg == ST_SEND;

   // only pin-enable and guards take written data
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         protect_pin_enable_reg <= STATUS_RESET[PROTECT_PIN_ENABLE_BIT];
         guards_pin_reg <= 2'b00;
      end else if (status_write_done && !status_write_blocked) begin
         protect_pin_enable_reg <= rx_byte[PROTECT_PIN_ENABLE_BIT];
         guards_pin_reg[1:0] <= {rx_byte[BLOCK_GUARD_HI_BIT], rx_byte[BLOCK_GUARD_LO_BIT]};
      end
   end

   // serial id writes gated by lock
   always_ff @(posedge clk_sys) begin
      if (rst)
         lock_reg <= STATUS_RESET[SERIAL_ID_LOCK_BIT];
      else if (serial_id_lock_set)
         lock_reg <= 1'b1;
   end

   // completed write or special clears latch
   always_ff @(posedge clk_sys) begin
      if (rst)
         latch_reg <= STATUS_RESET[WRITE_LATCH_BIT];
      else if (frame_end && opcode_reg == WRITE_LATCH_SET_CMD && opcode_seen)
         latch_reg <= 1'b1;
      else if (frame_end && opcode_seen
               && (opcode_reg == WRITE_LATCH_CLEAR_CMD || opcode_reg == STATUS_WRITE_CMD
                   || opcode_reg == ARRAY_WRITE_CMD || opcode_reg == CLOCK_REGS_WRITE_CMD
                   || opcode_reg == SERIAL_ID_WRITE_CMD || opcode_reg == SAVE_CMD
                   || opcode_reg == RESTORE_CMD || opcode_reg == AUTO_SAVE_ON_CMD
                   || opcode_reg == AUTO_SAVE_OFF_CMD))
         latch_reg <= 1'b0;
   end

   wire op_ok = state_reg == ST_OPCODE && byte_done && opcode_allowed;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cmd_events <= '0;
      end else begin
         cmd_events.save_start <= op_ok && rx_byte == SAVE_CMD;
         cmd_events.restore_start <= op_ok && rx_byte == RESTORE_CMD;
         cmd_events.auto_save_on <= op_ok && rx_byte == AUTO_SAVE_ON_CMD;
         cmd_events.auto_save_off <= op_ok && rx_byte == AUTO_SAVE_OFF_CMD;
         cmd_events.sleep_start <= op_ok && rx_byte == SLEEP_CMD;
         cmd_events.serial_id_write_ok <= op_ok && rx_byte == SERIAL_ID_WRITE_CMD && !lock_reg;
         cmd_events.array_cmd <= op_ok && (rx_byte == ARRAY_READ_CMD
            || rx_byte == ARRAY_READ_FAST_CMD || rx_byte == ARRAY_WRITE_CMD);
         cmd_events.clock_regs_cmd <= op_ok && (rx_byte == CLOCK_REGS_READ_CMD
            || rx_byte == CLOCK_REGS_READ_FAST_CMD || rx_byte == CLOCK_REGS_WRITE_CMD);
         cmd_events.id_read_cmd <= op_ok && (rx_byte == PART_ID_READ_CMD
            || rx_byte == PART_ID_READ_FAST_CMD || rx_byte == SERIAL_ID_READ_CMD
            || rx_byte == SERIAL_ID_READ_FAST_CMD);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst)
         addr_guarded <= 1'b0;
      else
         case (guards_pin_reg[1:0])
            2'b01: addr_guarded <= array_addr >= GUARD_QUARTER_BASE;
            2'b10: addr_guarded <= array_addr >= GUARD_HALF_BASE;
            2'b11: addr_guarded <= 1'b1;
            default: addr_guarded <= 1'b0;
         endcase
   end

   // standby only after delay and busy clear
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         standby_cnt_reg <= '0;
         active_power <= 1'b0;
      end else if (!sel_n) begin
         standby_cnt_reg <= '0;
         active_power <= 1'b1;
      end else if (active_power) begin
         if (standby_cnt_reg < STANDBY_DELAY_CYCLES[$bits(standby_cnt_reg)-1:0])
            standby_cnt_reg <= standby_cnt_reg + 1'b1;
         else if (!nv_busy)
            active_power <= 1'b0;
      end
   end

   a_busy_keeps_active: assert property (@(posedge clk_sys) disable iff (rst)
      active_power && nv_busy |=> active_power)
      else $error("standby entered while busy");
   a_reserved_bits_zero: assert property (@(posedge clk_sys) disable iff (rst)
      status_out[5:4] == 2'b00)
      else $error("reserved status bits nonzero");
   a_lock_sticky: assert property (@(posedge clk_sys) disable iff (rst)
      $past(lock_reg) |-> lock_reg)
      else $error("serial id lock cleared");
   a_blocked_write: assert property (@(posedge clk_sys) disable iff (rst)
      status_write_done && status_write_blocked |=> $stable(guards_pin_reg) && $stable(protect_pin_enable_reg))
      else $error("status write not blocked");
   a_busy_bit: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(miso_oe) |-> tx_reg[BUSY_BIT] == $past(nv_busy))
      else $error("busy bit wrong");
   a_ignore_quiet: assert property (@(posedge clk_sys) disable iff (rst)
      state_reg == ST_IGNORE && !sel_n |=> !miso_oe)
      else $error("output driven in ignore");
   a_fast_dummy: assert property (@(posedge clk_sys) disable iff (rst)
      state_reg == ST_OPCODE && byte_done && opcode_allowed && is_status_read_fast
      |=> state_reg == ST_DUMMY)
      else $error("fast read skipped dummy");
   // latch cleared after status write frame
   a_latch_cleared: assert property (@(posedge clk_sys) disable iff (rst)
      frame_end && opcode_seen && opcode_reg == STATUS_WRITE_CMD |=> !latch_reg)
      else $error("latch not cleared");
   a_latch_set: assert property (@(posedge clk_sys) disable iff (rst)
      frame_end && state_reg == ST_IGNORE && opcode_reg == WRITE_LATCH_SET_CMD |=> latch_reg)
      else $error("latch not set");
   a_plain_read_send: assert property (@(posedge clk_sys) disable iff (rst)
      state_reg == ST_OPCODE && byte_done && is_status_read |=> state_reg == ST_SEND && miso_oe)
      else $error("plain read not sending");
endmodule

// file: spi_master_model.sv
`timescale 1ns/1ps
module spi_master_model (
   input wire logic clk_sys,
   input wire logic miso_o,
   input wire logic miso_oe,
   output spi_status_pkg::spi_in_t spi_in,
   output logic oe_seen
);
   import spi_status_pkg::*;
   logic last_bit;
   initial begin
      spi_in = '{sel_n: 1'b1, sck: 1'b0, mosi: 1'b1};
      oe_seen = 1'b0;
      last_bit = 1'b1;
   end
   // Half of the 80 ns serial clock
   task automatic half();
      repeat (4) @(negedge clk_sys);
   endtask
   // tag: select fall opens frame, MSB first
   task automatic xfer(input logic [7:0] b0, input logic [7:0] b1, input int n,
                       output logic [7:0] rx);
      logic [7:0] cur;
      @(negedge clk_sys);
      spi_in.sel_n = 1'b0;
      oe_seen = 1'b0;
      for (int k = 0; k < n; k++) begin
         cur = (k == 0) ? b0 : b1;
         for (int i = 7; i >= 0; i--) begin
            spi_in.mosi = cur[i];
            last_bit = cur[i];
            half();
            spi_in.sck = 1'b1;
            half();
            // Sample late: bit stands until the fall
            rx = {rx[6:0], miso_o};
            if (miso_oe) oe_seen = 1'b1;
            spi_in.sck = 1'b0;
         end
      end
      half();
      spi_in.sel_n = 1'b1;
      // Released line shows no stale value
      spi_in.mosi = ~last_bit;
      repeat (8) @(negedge clk_sys);
   endtask
endmodule

// file: tb_spi_nvsram_command_status.sv
`timescale 1ns/1ps
module tb_spi_nvsram_command_status;
   import spi_status_pkg::*;
   localparam int SBY = 2;
   logic clk_sys, rst, write_protect_n, nv_busy, serial_id_lock_set;
   logic [16:0] array_addr;
   spi_in_t spi_in;
   logic miso_o, miso_oe, active_power, addr_guarded, oe_seen;
   logic [7:0] status_out, rx, v;
   cmd_events_t cmd_events;
   logic [8:0] ev_acc;
   logic ev_clr;
   logic protect_pin_enable, lock, wel, g;
   logic [1:0] bp;
   int errors = 0;
   int checked = 0;
   int cycles = 0;
   int seed = 32'h8b35dedd;
   logic [7:0] ops [16] = '{8'h3c, 8'h60, 8'h59, 8'h19, 8'hb9, 8'hc2, 8'h03, 8'h0b,
                            8'h02, 8'h13, 8'h1d, 8'h12, 8'h9f, 8'h99, 8'hc3, 8'hc9};
   int ebit [16] = '{8, 7, 6, 5, 4, 3, 2, 2, 2, 1, 1, 1, 0, 0, 0, 0};
   logic [15:0] clr = 16'b1111_0100_1001_0000;
   logic [16:0] addrs [5];
   spi_nvsram_command_status #(.STANDBY_DELAY_CYCLES(SBY)) spi_nvsram_command_status_inst (
      .clk_sys(clk_sys), .rst(rst), .spi_in(spi_in), .write_protect_n(write_protect_n),
      .nv_busy(nv_busy), .serial_id_lock_set(serial_id_lock_set), .array_addr(array_addr),
      .miso_o(miso_o), .miso_oe(miso_oe), .active_power(active_power),
      .status_out(status_out), .addr_guarded(addr_guarded), .cmd_events(cmd_events));
   spi_master_model spi_master_model_inst (.clk_sys(clk_sys), .miso_o(miso_o),
      .miso_oe(miso_oe), .spi_in(spi_in), .oe_seen(oe_seen));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      ev_acc <= ev_clr ? 9'h000 : (ev_acc | cmd_events);
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         errors++;
         finish_test();
      end
   end
   function automatic logic [7:0] exp_st();
      return {protect_pin_enable, lock, 2'b00, bp, wel, nv_busy};
   endfunction
   task automatic finish_test();
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic clear_ev();
      ev_clr = 1'b1;
      @(negedge clk_sys);
      ev_clr = 1'b0;
   endtask
   task automatic frame(input logic [7:0] op, input logic [7:0] d, input int n);
      spi_master_model_inst.xfer(op, d, n, rx);
   endtask
   task automatic write_latch_set_cmd();
      frame(WRITE_LATCH_SET_CMD, 8'h00, 1);
      wel = 1'b1;
   endtask
   task automatic status_write_cmd(input logic [7:0] val);
      write_latch_set_cmd();
      frame(STATUS_WRITE_CMD, val, 2);
      if (!(protect_pin_enable && !write_protect_n)) begin
         protect_pin_enable = val[7];
         bp = val[3:2];
      end
      wel = 1'b0;
   endtask
   task automatic status_read_cmd(input bit fast);
      frame(fast ? STATUS_READ_FAST_CMD : STATUS_READ_CMD, 8'h00, fast ? 3 : 2);
      check("status read", exp_st(), rx);
      check("read oe", 1'b1, oe_seen);
      check("status live", exp_st(), status_out);
   endtask
   initial begin
      rst = 1'b1;
      write_protect_n = 1'b1;
      nv_busy = 1'b0;
      serial_id_lock_set = 1'b0;
      array_addr = '0;
      ev_clr = 1'b1;
      {protect_pin_enable, lock, wel, bp} = '0;
      repeat (4) @(negedge clk_sys);
      rst = 1'b0;
      repeat (3) @(negedge clk_sys);
      check("reset status", 8'h00, status_out);
      write_latch_set_cmd();
      status_read_cmd(0);
      frame(WRITE_LATCH_CLEAR_CMD, 8'h00, 1);
      wel = 1'b0;
      status_read_cmd(1);
      // Status write with latch clear is refused
      frame(STATUS_WRITE_CMD, 8'h8c, 2);
      check("refused write", exp_st(), status_out);
      for (int i = 0; i < 4; i++) begin
         v = 8'($random(seed));
         v[3:2] = i[1:0];
         status_write_cmd(v);
         status_read_cmd(i[0]);
         addrs = '{17'h0ffff, 17'h10000, 17'h17fff, 17'h18000, 17'h00000};
         addrs[4] = 17'($random(seed));
         for (int j = 0; j < 5; j++) begin
            array_addr = addrs[j];
            repeat (3) @(negedge clk_sys);
            g = (bp == 2'd3) || (bp == 2'd2 && array_addr >= 17'h10000) ||
                (bp == 2'd1 && array_addr >= 17'h18000);
            check("guard", g, addr_guarded);
         end
      end
      status_write_cmd(8'h8c);
      write_protect_n = 1'b0;
      status_write_cmd(8'h00);
      check("pin blocked", exp_st() & 8'hfd, status_out & 8'hfd);
      write_protect_n = 1'b1;
      status_write_cmd(8'h00);
      check("pin open", exp_st(), status_out);
      frame(RESERVED_CMD, 8'h05, 2);
      check("reserved oe", 1'b0, oe_seen);
      for (int i = 0; i < 16; i++) begin
         write_latch_set_cmd();
         clear_ev();
         frame(ops[i], 8'h00, 1);
         check("event", 9'h001 << ebit[i], ev_acc);
         if (clr[15 - i]) wel = 1'b0;
         check("latch after op", exp_st(), status_out);
      end
      serial_id_lock_set = 1'b1;
      @(negedge clk_sys);
      serial_id_lock_set = 1'b0;
      lock = 1'b1;
      write_latch_set_cmd();
      clear_ev();
      frame(SERIAL_ID_WRITE_CMD, 8'h00, 1);
      check("locked write", 9'h000, ev_acc);
      wel = 1'b0;
      check("latch locked op", exp_st(), status_out);
      status_write_cmd(8'h00);
      check("lock kept", exp_st(), status_out);
      nv_busy = 1'b1;
      status_read_cmd(0);
      check("active busy", 1'b1, active_power);
      nv_busy = 1'b0;
      repeat (SBY + 6) @(negedge clk_sys);
      check("standby", 1'b0, active_power);
      finish_test();
   end
endmodule
